// ==== ucp_core.sv ====
// transceiver-side packet timing: line state reports, tx/rx latencies,
// register abort on dir and response timeout
// assumes link and analog front end share clk_i; inputs are synchronous
module ucp_core
  import ucp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // link side
  input  wire logic [7:0] data_i,
  input  wire logic       stp_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  output logic            dir_o,
  output logic            nxt_o,
  // front end and configuration
  input  wire logic [1:0] line_state_i,
  input  wire logic [1:0] speed_select_i,
  input  wire logic [1:0] vbus_state_i,
  input  wire logic       rx_active_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       reg_read_done_i,
  // events
  output logic            tx_start_o,
  output logic            tx_end_o,
  output logic            resp_timeout_o,
  output logic            reg_abort_o,
  output logic      [1:0] line_state_field_o
);
  import ucp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic ucp_speed_t spd_class(input logic [1:0] sel);
    if (sel == SPD_SEL_HS) return UCP_SPD_HS;
    if (sel == SPD_SEL_LS) return UCP_SPD_LS;
    return UCP_SPD_FS;
  endfunction : spd_class

  // pick one of three per-speed counts
  function automatic logic [DLY_W-1:0] by_speed(input ucp_speed_t s,
                                                input logic [DLY_W-1:0] hs,
                                                input logic [DLY_W-1:0] fs,
                                                input logic [DLY_W-1:0] ls);
    unique case (s)
      UCP_SPD_HS: return hs;
      UCP_SPD_FS: return fs;
      default:    return ls;
    endcase
  endfunction : by_speed

  typedef enum logic [1:0] {ST_IDLE, ST_TURN, ST_RXCMD, ST_RX} ucp_state_t;

  ucp_speed_t       spd;
  ucp_state_t       state_q;
  ucp_rxcmd_t       rxcmd_q;
  logic [1:0]       ls_prev_q;
  logic [1:0]       vbus_prev_q;
  logic             rx_act_prev_q;
  logic             rxcmd_pend_q;
  logic             rx_go_q;
  logic             tx_busy_q;
  logic             tx_sof_q;
  logic             reg_busy_q;
  logic             idle_go;
  logic             cmd_ok;
  logic             tx_take;
  logic [DLY_N-1:0] dly_start;
  logic [DLY_N-1:0] dly_clear;
  logic [DLY_N-1:0] dly_fire;
  logic [DLY_W-1:0] dly_cnt [DLY_N];

  assign spd     = spd_class(speed_select_i);
  // receive start fire claims the bus in its own cycle, so dir follows one clock later
  assign idle_go = (state_q == ST_IDLE) && !tx_busy_q &&
                   (rx_go_q || dly_fire[DLY_RXS] || rxcmd_pend_q);
  assign cmd_ok  = (state_q == ST_IDLE) && !dir_o && !tx_busy_q && !reg_busy_q && !idle_go;
  assign tx_take = cmd_ok && (data_i[7:6] == CMD_TX);

  ////////////////////////////////////////////////////////////////////////////
  // latency counters

  // starts and counts of each delay channel
  always_comb begin
    dly_start          = '0;
    dly_clear          = '0;
    dly_start[DLY_LS]  = (line_state_i != ls_prev_q);
    dly_start[DLY_TXS] = tx_take;
    dly_start[DLY_TXE] = tx_busy_q && stp_i;
    dly_start[DLY_RXS] = rx_active_i && !rx_act_prev_q;
    dly_start[DLY_RXE] = !rx_active_i && rx_act_prev_q;
    dly_start[DLY_RSP] = dly_fire[DLY_TXE];
    dly_clear[DLY_RSP] = dly_fire[DLY_RXS];       // a reply cancels the timeout
    dly_cnt[DLY_LS]    = (line_state_i != LS_SE0) ? LAT_JK :
                         by_speed(spd, LAT_SE0_HS, LAT_SE0_FS, LAT_SE0_LS);
    dly_cnt[DLY_TXS]   = by_speed(spd, LAT_TXS_HS, LAT_TXS_FS, LAT_TXS_LS);
    dly_cnt[DLY_TXE]   = tx_sof_q ? LAT_TXE_SOF : LAT_TXE_PKT;
    dly_cnt[DLY_RXS]   = LAT_RXS;
    dly_cnt[DLY_RXE]   = by_speed(spd, LAT_RXE_HS, LAT_RXE_FS, LAT_RXE_LS);
    dly_cnt[DLY_RSP]   = by_speed(spd, TMO_RSP_HS, TMO_RSP_FS, TMO_RSP_LS);
  end

  // one counter per channel
  for (genvar g = 0; g < DLY_N; g++) begin : g_dly
    ucp_delay u_dly (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .start_i (dly_start[g]),
      .clear_i (dly_clear[g]),
      .count_i (dly_cnt[g]),
      .fire_o  (dly_fire[g])
    );
  end

  assign tx_start_o     = dly_fire[DLY_TXS];
  assign tx_end_o       = dly_fire[DLY_TXE];
  assign resp_timeout_o = dly_fire[DLY_RSP];

  ////////////////////////////////////////////////////////////////////////////
  // front end edge history

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ls_prev_q     <= LS_SE0;
      vbus_prev_q   <= 2'h0;
      rx_act_prev_q <= 1'b0;
    end else begin
      ls_prev_q     <= line_state_i;
      vbus_prev_q   <= vbus_state_i;
      rx_act_prev_q <= rx_active_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status byte contents and pending flag; a new event wins over the send

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxcmd_q            <= '0;
      line_state_field_o <= LS_SE0;
      rxcmd_pend_q       <= 1'b0;
    end else begin
      rxcmd_q.vbus_state <= vbus_state_i;
      if (dly_fire[DLY_LS]) begin
        rxcmd_q.line_state <= ls_prev_q;
        line_state_field_o <= ls_prev_q;
      end
      if (dly_fire[DLY_RXS]) rxcmd_q.rx_event <= RX_EVT_ACTIVE;
      if (dly_fire[DLY_RXE]) rxcmd_q.rx_event <= RX_EVT_IDLE;
      if (dly_fire[DLY_LS] || (vbus_state_i != vbus_prev_q)) begin
        rxcmd_pend_q <= 1'b1;
      end else if (state_q == ST_RXCMD) begin
        rxcmd_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link command tracking

  // transmit in flight from command to end latency
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_busy_q <= 1'b0;
      tx_sof_q  <= 1'b0;
    end else if (tx_take) begin
      tx_busy_q <= 1'b1;
      tx_sof_q  <= (data_i[3:0] == PID_SOF);
    end else if (dly_fire[DLY_TXE]) begin
      tx_busy_q <= 1'b0;
    end
  end

  // register operation in flight; raising dir over it aborts it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_busy_q  <= 1'b0;
      reg_abort_o <= 1'b0;
    end else begin
      reg_abort_o <= idle_go && reg_busy_q;
      if (idle_go && reg_busy_q) begin
        reg_busy_q <= 1'b0;
      end else if (cmd_ok && (data_i[7:6] == CMD_REGW || data_i[7:6] == CMD_REGR)) begin
        reg_busy_q <= 1'b1;
      end else if (stp_i || reg_read_done_i) begin
        reg_busy_q <= 1'b0;
      end
    end
  end

  // received packet waiting for the bus
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_go_q <= 1'b0;
    end else if (dly_fire[DLY_RXS]) begin
      rx_go_q <= 1'b1;
    end else if (state_q == ST_RX || dly_fire[DLY_RXE]) begin
      rx_go_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus direction and data

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= ST_IDLE;
      dir_o     <= 1'b0;
      nxt_o     <= 1'b0;
      data_oe_o <= 1'b0;
      data_o    <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (idle_go) begin
            state_q <= ST_TURN;
            dir_o   <= 1'b1;                             // turnaround cycle
          end
        end
        ST_TURN: begin
          data_oe_o <= 1'b1;
          if (rx_go_q) begin
            state_q <= ST_RX;
            nxt_o   <= 1'b1;                             // dir with nxt: receive active
            data_o  <= 8'h00;
          end else begin
            state_q <= ST_RXCMD;
            data_o  <= rxcmd_q;
          end
        end
        ST_RXCMD: begin
          state_q   <= ST_IDLE;
          dir_o     <= 1'b0;
          data_oe_o <= 1'b0;
        end
        ST_RX: begin
          if (dly_fire[DLY_RXE]) begin
            state_q   <= ST_IDLE;
            dir_o     <= 1'b0;
            nxt_o     <= 1'b0;
            data_oe_o <= 1'b0;
          end else begin
            nxt_o  <= rx_valid_i;
            data_o <= rx_valid_i ? rx_data_i : rxcmd_q;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [DLY_W-1:0] rsp_age_q;
  ucp_speed_t       rsp_spd_q;

  // cycles since the last transmit end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_age_q <= '0;
      rsp_spd_q <= UCP_SPD_HS;
    end else if (tx_end_o) begin
      rsp_age_q <= 10'h001;
      rsp_spd_q <= spd;
    end else if (rsp_age_q != '0 && rsp_age_q != 10'h3FF) begin
      rsp_age_q <= rsp_age_q + 10'h001;
    end
  end

  reg_abort_a: assert property (idle_go && reg_busy_q |=> reg_abort_o && dir_o && !reg_busy_q)
    else $error("register operation not aborted on dir");
  ls_jk_lat_a: assert property (dly_start[DLY_LS] && line_state_i != LS_SE0
      ##1 !dly_start[DLY_LS] [*3] |=> dly_fire[DLY_LS])
    else $error("J/K line state report not after four clocks");
  ls_se0_lat_a: assert property (dly_start[DLY_LS] && line_state_i == LS_SE0
      && spd == UCP_SPD_LS |-> ##[16:18] (dly_fire[DLY_LS] || dly_start[DLY_LS]))
    else $error("low-speed SE0 report outside window");
  tx_start_hs_a: assert property (tx_take && spd == UCP_SPD_HS |-> ##[1:2] tx_start_o)
    else $error("high-speed transmit start latency wrong");
  tx_start_ls_a: assert property (tx_take && spd == UCP_SPD_LS |-> ##[74:75] tx_start_o)
    else $error("low-speed transmit start latency wrong");
  tx_end_sof_a: assert property (dly_start[DLY_TXE] && tx_sof_q |-> ##[6:9] tx_end_o)
    else $error("start-of-frame transmit end latency wrong");
  rx_end_fs_a: assert property (dly_start[DLY_RXE] && spd == UCP_SPD_FS
      |-> ##[17:18] (dly_fire[DLY_RXE] || dly_start[DLY_RXE]))
    else $error("full-speed receive end latency wrong");
  rsp_tmo_a: assert property (resp_timeout_o |-> rsp_age_q == ((rsp_spd_q == UCP_SPD_HS) ? 10'h05C :
      (rsp_spd_q == UCP_SPD_FS) ? 10'h050 : 10'h2CE))
    else $error("response timeout count wrong");

endmodule : ucp_core

// ==== ucp_pkg.sv ====
// constants, types and latency tables for the transceiver packet timing core
// assumes one interface clock shared with the link; all counts are in its cycles
package ucp_pkg;

  // width of every latency counter
  localparam int DLY_W = 10;

  // delay channels, one counter each
  localparam int DLY_LS  = 0;
  localparam int DLY_TXS = 1;
  localparam int DLY_TXE = 2;
  localparam int DLY_RXS = 3;
  localparam int DLY_RXE = 4;
  localparam int DLY_RSP = 5;
  localparam int DLY_N   = 6;

  // speed_select encodings
  localparam logic [1:0] SPD_SEL_HS = 2'h0;
  localparam logic [1:0] SPD_SEL_LS = 2'h2;

  // line_state_field values
  localparam logic [1:0] LS_SE0 = 2'h0;

  // link command byte: command in the top two bits, PID in the low four
  localparam logic [1:0] CMD_TX   = 2'h1;
  localparam logic [1:0] CMD_REGW = 2'h2;
  localparam logic [1:0] CMD_REGR = 2'h3;
  localparam logic [3:0] PID_SOF  = 4'h5;

  // receive event codes in the status byte
  localparam logic [1:0] RX_EVT_IDLE   = 2'h0;
  localparam logic [1:0] RX_EVT_ACTIVE = 2'h1;

  // line state report latencies
  localparam logic [DLY_W-1:0] LAT_JK     = 10'h004;
  localparam logic [DLY_W-1:0] LAT_SE0_HS = 10'h004;
  localparam logic [DLY_W-1:0] LAT_SE0_FS = 10'h004;
  localparam logic [DLY_W-1:0] LAT_SE0_LS = 10'h010;
  // transmit latencies
  localparam logic [DLY_W-1:0] LAT_TXS_HS  = 10'h001;
  localparam logic [DLY_W-1:0] LAT_TXS_FS  = 10'h006;
  localparam logic [DLY_W-1:0] LAT_TXS_LS  = 10'h04A;
  localparam logic [DLY_W-1:0] LAT_TXE_PKT = 10'h003;
  localparam logic [DLY_W-1:0] LAT_TXE_SOF = 10'h006;
  // receive latencies
  localparam logic [DLY_W-1:0] LAT_RXS    = 10'h005;
  localparam logic [DLY_W-1:0] LAT_RXE_HS = 10'h005;
  localparam logic [DLY_W-1:0] LAT_RXE_FS = 10'h011;
  localparam logic [DLY_W-1:0] LAT_RXE_LS = 10'h07A;
  // response timeouts
  localparam logic [DLY_W-1:0] TMO_RSP_HS = 10'h05C;
  localparam logic [DLY_W-1:0] TMO_RSP_FS = 10'h050;
  localparam logic [DLY_W-1:0] TMO_RSP_LS = 10'h2CE;

  typedef enum logic [1:0] {
    UCP_SPD_HS,
    UCP_SPD_FS,
    UCP_SPD_LS
  } ucp_speed_t;

  // status byte sent to the link while dir is high
  typedef struct packed {
    logic [1:0] alt;
    logic [1:0] rx_event;
    logic [1:0] vbus_state;
    logic [1:0] line_state;
  } ucp_rxcmd_t;

endpackage : ucp_pkg

// ==== ucp_delay.sv ====
// one-shot cycle counter: fires a single pulse count_i cycles after start_i
// assumes count_i is at least one and stable in the start cycle
module ucp_delay
  import ucp_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             start_i,
  input  wire logic             clear_i,
  input  wire logic [DLY_W-1:0] count_i,
  output logic                  fire_o
);

  logic [DLY_W-1:0] cnt_q;

  // countdown; a restart reloads, a clear abandons
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= '0;
      fire_o <= 1'b0;
    end else if (clear_i) begin
      cnt_q  <= '0;
      fire_o <= 1'b0;
    end else if (start_i) begin
      cnt_q  <= count_i - 10'h001;
      fire_o <= (count_i == 10'h001);
    end else begin
      cnt_q  <= (cnt_q != '0) ? cnt_q - 10'h001 : cnt_q;
      fire_o <= (cnt_q == 10'h001);
    end
  end

endmodule : ucp_delay

// ==== ucp_link_model.sv ====
// link-side partner: issues commands and stop toward the transceiver core
// assumes the core samples on the rising clk_i; this model drives on falling
module ucp_link_model (
  input  wire logic       clk_i,
  input  wire logic       dir_i,
  input  wire logic       abort_i,
  output logic      [7:0] data_o,
  output logic            stp_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] drv_q = 8'h00;
  logic [7:0] lst_q = 8'h00;

  initial stp_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // released bus toggles so stale data never looks valid
  always @(negedge clk_i) begin
    lst_q <= dir_i ? ~lst_q : drv_q;
  end
  assign data_o = dir_i ? lst_q : drv_q;

  // one command byte for one cycle, then idle
  task automatic send_cmd(input logic [7:0] cmd);
    drv_q = cmd;
    @(negedge clk_i);
    drv_q = 8'h00;
  endtask : send_cmd

  // end of transmit or register op
  task automatic stop();
    stp_o = 1'b1;
    @(negedge clk_i);
    stp_o = 1'b0;
  endtask : stop

  // register write, reissued after each abort until eight tries are used
  task automatic reg_write(input logic [7:0] cmd, output int tries);
    logic ab;
    tries = 0;
    ab    = 1'b1;
    while (ab && tries < 8) begin
      ab = 1'b0;
      tries++;
      send_cmd(cmd);
      repeat (10) begin
        @(negedge clk_i);
        ab = ab | abort_i;
      end
      if (ab) begin
        while (dir_i) @(negedge clk_i);
      end else begin
        stop();
      end
    end
  endtask : reg_write
endmodule : ucp_link_model

// ==== ucp_core_tb_top.sv ====
// self-checking bench for the transceiver packet timing core
// assumes one 20 MHz clock; inputs change on the falling edge
module ucp_core_tb_top;
  import ucp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  wire  [7:0] data_i;
  wire        stp;
  logic [7:0] data_o;
  logic       data_oe, dir, nxt, tx_start, tx_end, tmo, abort;
  logic [1:0] lsf;
  logic [1:0] line = 2'h0;
  logic [1:0] spd = 2'h0;
  logic       rxa = 1'b0;
  logic       rxv = 1'b0;
  logic [7:0] rxd = 8'h00;
  int         n_errors = 0;
  int         n_tests = 0;
  int         txs_tab [3] = '{1, 6, 74};
  int         tmo_tab [3] = '{92, 80, 718};
  int         se0_tab [3] = '{4, 4, 16};
  int         rxe_tab [3] = '{5, 17, 122};
  logic [1:0] spd_tab [3] = '{2'h0, 2'h1, 2'h2};

  ////////////////////////////////////////////////////////////////////////////
  // clock and instances
  initial forever #25 clk = ~clk;

  ucp_core uut (.clk_i(clk), .rstn_i(rstn), .data_i(data_i), .stp_i(stp),
    .data_o(data_o), .data_oe_o(data_oe), .dir_o(dir), .nxt_o(nxt),
    .line_state_i(line), .speed_select_i(spd), .vbus_state_i(2'h2),
    .rx_active_i(rxa), .rx_valid_i(rxv), .rx_data_i(rxd), .reg_read_done_i(1'b0),
    .tx_start_o(tx_start), .tx_end_o(tx_end), .resp_timeout_o(tmo),
    .reg_abort_o(abort), .line_state_field_o(lsf));

  ucp_link_model link (.clk_i(clk), .dir_i(dir), .abort_i(abort),
    .data_o(data_i), .stp_o(stp));

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // cycles until the selected event, bounded
  task automatic wait_hi(input int sel, output int n);
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
      case (sel)
        0: s = tx_start;
        1: s = tx_end;
        2: s = tmo;
        3: s = (lsf === line);
        4: s = data_oe;
        5: s = nxt;
        6: s = ~dir;
        default: s = abort;
      endcase
    end
  endtask : wait_hi

  // transmit start, end and response timeout at one speed
  task automatic t_tx(input int s);
    int n;
    spd = spd_tab[s];
    repeat (4) @(negedge clk);
    fork link.send_cmd(8'h41); wait_hi(0, n); join
    chk(n, txs_tab[s]);
    repeat (3) @(negedge clk);
    fork link.stop(); wait_hi(1, n); join
    if (s == 0) chk(n, 3);
    wait_hi(2, n);
    chk(n, tmo_tab[s]);
    if (s == 0) begin
      fork link.send_cmd(8'h45); wait_hi(0, n); join
      repeat (3) @(negedge clk);
      fork link.stop(); wait_hi(1, n); join
      chk(n, 6);
      wait_hi(2, n);
    end
    $display("test tx speed %0d done", s);
  endtask : t_tx

  // line state report latency and status byte content
  task automatic t_line(input int s);
    int n;
    spd = spd_tab[s];
    repeat (4) @(negedge clk);
    line = 2'h1;
    wait_hi(3, n);
    chk(n, 5);
    wait_hi(4, n);
    chk(data_o[5:0], 6'h09);
    repeat (4) @(negedge clk);
    line = 2'h0;
    wait_hi(3, n);
    chk(n, se0_tab[s] + 1);
    repeat (6) @(negedge clk);
    $display("test line speed %0d done", s);
  endtask : t_line

  // receive start and end latencies, one data byte
  task automatic t_rx(input int s);
    int n;
    spd = spd_tab[s];
    repeat (4) @(negedge clk);
    rxa = 1'b1;
    wait_hi(5, n);
    chk(n, 7);
    chk({dir, data_oe}, 2'h3);
    rxv = 1'b1;
    rxd = 8'hA5;
    @(negedge clk);
    rxv = 1'b0;
    chk({nxt, data_o}, 9'h1A5);
    @(negedge clk);
    chk(nxt, 1'b0);
    rxa = 1'b0;
    wait_hi(6, n);
    chk(n, rxe_tab[s] + 1);
    // second packet right after dir drops
    rxa = 1'b1;
    wait_hi(5, n);
    chk(n, 7);
    rxa = 1'b0;
    wait_hi(6, n);
    chk(n, rxe_tab[s] + 1);
    repeat (10) @(negedge clk);
    $display("test rx speed %0d done", s);
  endtask : t_rx

  // host reset and chirp handshake as line state reports; chirp lengths scaled to cycles
  task automatic t_chirp();
    int n;
    spd  = SPD_SEL_HS;
    line = 2'h1;                                   // full-speed attach
    repeat (12) @(negedge clk);
    line = LS_SE0;
    wait_hi(3, n);
    chk(n, 5);
    repeat (8) @(negedge clk);
    line = 2'h2;                                   // peripheral chirp K
    wait_hi(3, n);
    chk(n, 5);
    repeat (8) @(negedge clk);
    line = LS_SE0;                                 // bus leaves chirp K
    wait_hi(3, n);
    chk(n, 5);
    repeat (8) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      line = i[0] ? 2'h1 : 2'h2;
      wait_hi(3, n);
      chk(n, 5);
      repeat (8) @(negedge clk);
    end
    line = 2'h2;                                   // squelch
    wait_hi(3, n);
    chk(n, 5);
    repeat (8) @(negedge clk);
    $display("test chirp done");
  endtask : t_chirp

  // register write cut short by a status byte, then reissued
  task automatic t_abort();
    int n;
    int tries;
    fork
      link.reg_write(8'h85, tries);
      begin
        @(negedge clk);
        line = 2'h2;
        wait_hi(7, n);
        chk(dir, 1'b1);
      end
    join
    chk(tries, 2);
    $display("test abort done");
  endtask : t_abort

  // verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    chk({dir, data_oe, lsf, tx_start, abort}, 6'h00);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    for (int s = 0; s < 3; s++) t_line(s);
    for (int s = 0; s < 3; s++) t_tx(s);
    for (int s = 0; s < 3; s++) t_rx(s);
    t_chirp();
    line = 2'h1;
    repeat (12) @(negedge clk);
    t_abort();
    end_of_test();
  end

  // hang guard, well beyond the expected run
  initial begin
    #(60000 * 50);
    n_errors++;
    end_of_test();
  end
endmodule : ucp_core_tb_top
